/* design/ppcd_port.sv */
`timescale 1ns/1ns
// Function
// [RULE1] pull_edge_select picks event edge and pull polarity.
// [RULE2] Input with pull enable: select 0 pulls up, 1 pulls down.
// [RULE3] Event enable: select 0 falling, 1 rising edge; any direction.
// [RULE4] Output drives output level; drive_reduce lowers strength; no pull.
// [RULE5] pull_edge_select fixed 1 on ports A and B, 0 on AD.
// [RULE6] Edge interrupts only on event-capable ports, not on A or B.
// [RULE7] Register reads are synchronous to the internal clock.
// [RULE8] Port A data register at index 0x0, resets zero, RW.
// [RULE9] General purpose output drives stored data bit onto pin.
// [RULE10] Read returns register bit if direction 1, else synced pin.
// [RULE11] Enabled LCD segment overrides every other pin function.
// [RULE12] Port A bit 3: tick clock output overrides GPIO unless LCD.
// [RULE13] Port A bit 1: nonmaskable request overrides GPIO unless LCD.
// [RULE14] Port A bit 0: maskable request overrides GPIO unless LCD.
// [RULE15] Port B data register at index 0x1, resets zero, LCD shared.
// [RULE16] Data registers writable anytime; read source follows direction.
// [RULE17] Direction 1 means output, 0 means input.
// [RULE18] Enabled LCD segment forces input and output disabled.
// [RULE19] Read after direction change may lag two cycles (sync).
module ppcd_port #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ppcd_pkg::WB_AW-1:0] adr_i,
  input wire logic [ppcd_pkg::WB_DW-1:0] dat_i,
  output logic [ppcd_pkg::WB_DW-1:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic [ppcd_pkg::PORT_W-1:0] a_pin_i,
  input wire logic [ppcd_pkg::PORT_W-1:0] b_pin_i,
  input wire logic [ppcd_pkg::PORT_W-1:0] e_pin_i,
  input wire logic [ppcd_pkg::PORT_W-1:0] lcd_seg_a_i,
  input wire logic [ppcd_pkg::PORT_W-1:0] lcd_seg_b_i,
  input wire logic tick_en_i,
  input wire logic tick_clk_i,
  input wire logic nmreq_en_i,
  input wire logic mreq_en_i,
  output ppcd_pkg::ppcd_pad_s a_pad_o,
  output ppcd_pkg::ppcd_pad_s b_pad_o,
  output ppcd_pkg::ppcd_pad_s e_pad_o,
  output logic nmreq_o,
  output logic mreq_o,
  output logic irq_o
);

  localparam int unsigned W = ppcd_pkg::PORT_W;

  function automatic ppcd_pkg::ppcd_pad_s pad_ctl(ppcd_pkg::ppcd_cfg_s c);
    ppcd_pkg::ppcd_pad_s p;
    logic [W-1:0] drv;
    logic [W-1:0] inp;
    drv = c.dir & ~c.lcd;
    inp = ~c.dir & ~c.lcd;
    p.oe_n = ~drv;
    p.dout = c.data & drv;
    p.pull_up = inp & c.pull_en & ~c.pull_sel;
    p.pull_dn = inp & c.pull_en & c.pull_sel;
    p.reduce = c.reduce & drv;
    return p;
  endfunction

  function automatic logic [W-1:0] rd_src(logic [W-1:0] dir,
      logic [W-1:0] data, logic [W-1:0] pin);
    return (dir & data) | (~dir & pin);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  logic [W-1:0] a_sync_q [SYNC_STAGES];
  logic [W-1:0] b_sync_q [SYNC_STAGES];
  logic [W-1:0] e_sync_q [SYNC_STAGES];
  logic [W-1:0] e_prev_q;
  logic [W-1:0] a_in;
  logic [W-1:0] b_in;
  logic [W-1:0] e_in;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        a_sync_q[i] <= ppcd_pkg::RST_REG;
        b_sync_q[i] <= ppcd_pkg::RST_REG;
        e_sync_q[i] <= ppcd_pkg::RST_REG;
      end
      e_prev_q <= ppcd_pkg::RST_REG;
    end else begin
      a_sync_q[0] <= a_pin_i;
      b_sync_q[0] <= b_pin_i;
      e_sync_q[0] <= e_pin_i;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        a_sync_q[i] <= a_sync_q[i-1];
        b_sync_q[i] <= b_sync_q[i-1];
        e_sync_q[i] <= e_sync_q[i-1];
      end
      e_prev_q <= e_in;
    end
  end

  assign a_in = a_sync_q[SYNC_STAGES-1];
  assign b_in = b_sync_q[SYNC_STAGES-1];
  assign e_in = e_sync_q[SYNC_STAGES-1];

  //////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave

  logic [W-1:0] reg_q [ppcd_pkg::NREG];
  logic [W-1:0] status_q;
  logic [ppcd_pkg::IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic hit;
  logic ack_q;
  logic [ppcd_pkg::WB_DW-1:0] dat_q;
  logic [W-1:0] rd_val;

  assign idx = adr_i[ppcd_pkg::IDX_LO +: ppcd_pkg::IDX_W];
  // Irq enable is the highest mapped index
  assign hit = (adr_i[ppcd_pkg::WB_AW-1:ppcd_pkg::IDX_LO+ppcd_pkg::IDX_W]
                == '0) && (idx <= ppcd_pkg::IDX_IRQ_ENABLE);
  // Unmapped addresses are acknowledged, read zero and ignore writes
  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i & sel_i[0] & hit;

  // Data registers, config and enable: plain storage, writable anytime
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ppcd_pkg::NREG; i++) begin
        reg_q[i] <= ppcd_pkg::RST_REG; // RULE8 RULE15
      end
    end else if (wr && idx != ppcd_pkg::IDX_IRQ_STATUS &&
                 idx != ppcd_pkg::IDX_IRQ_CLEAR) begin
      reg_q[idx] <= dat_i[W-1:0]; // RULE16
    end
  end

  // Read multiplexer; data ports follow the live direction bits
  // The whole decode sits under hit so an alias above the map reads zero
  always_comb begin
    rd_val = ppcd_pkg::RST_REG;
    if (hit) begin
      rd_val = reg_q[idx];
      unique case (idx)
        ppcd_pkg::IDX_A_DATA: begin
          rd_val = rd_src(reg_q[ppcd_pkg::IDX_A_DIR],
                          reg_q[ppcd_pkg::IDX_A_DATA],
                          a_in & ~lcd_seg_a_i); // RULE10 RULE18 RULE19
        end
        ppcd_pkg::IDX_B_DATA: begin
          rd_val = rd_src(reg_q[ppcd_pkg::IDX_B_DIR],
                          reg_q[ppcd_pkg::IDX_B_DATA],
                          b_in & ~lcd_seg_b_i); // RULE10 RULE18
        end
        ppcd_pkg::IDX_E_DATA: begin
          rd_val = rd_src(reg_q[ppcd_pkg::IDX_E_DIR],
                          reg_q[ppcd_pkg::IDX_E_DATA], e_in); // RULE10
        end
        ppcd_pkg::IDX_IRQ_STATUS: rd_val = status_q;
        ppcd_pkg::IDX_IRQ_CLEAR: rd_val = ppcd_pkg::RST_REG;
        default: ;
      endcase
    end
  end

  // Answer one cycle after the request, from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req && !we_i) begin
        dat_q <= {{(ppcd_pkg::WB_DW-W){1'b0}}, rd_val}; // RULE7
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  //////////////////////////////////////////////////////////////////////////
  // Edge events and interrupt

  logic [W-1:0] e_rise;
  logic [W-1:0] e_fall;
  logic [W-1:0] e_event;
  logic [W-1:0] clr;
  logic [W-1:0] e_sel;

  assign e_sel = reg_q[ppcd_pkg::IDX_E_PULL_SEL]; // RULE1
  assign e_rise = e_in & ~e_prev_q;
  assign e_fall = ~e_in & e_prev_q;
  // Edges are watched regardless of direction
  assign e_event = reg_q[ppcd_pkg::IDX_E_EVT_EN] &
                   ((e_sel & e_rise) | (~e_sel & e_fall)); // RULE3 RULE6
  assign clr = (wr && idx == ppcd_pkg::IDX_IRQ_CLEAR) ? dat_i[W-1:0]
               : ppcd_pkg::RST_REG;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= ppcd_pkg::RST_REG;
    end else begin
      // A new event beats a clear in the same cycle
      status_q <= (status_q & ~clr) | e_event;
    end
  end

  assign irq_o = |(status_q & reg_q[ppcd_pkg::IDX_IRQ_ENABLE]);

  //////////////////////////////////////////////////////////////////////////
  // Pad control

  ppcd_pkg::ppcd_cfg_s a_cfg;
  ppcd_pkg::ppcd_cfg_s b_cfg;
  ppcd_pkg::ppcd_cfg_s e_cfg;
  logic [W-1:0] a_dir_eff;
  logic [W-1:0] a_data_eff;
  logic tick_own;
  logic nmreq_own;
  logic mreq_own;
  ppcd_pkg::ppcd_pad_s a_pad_q;
  ppcd_pkg::ppcd_pad_s b_pad_q;
  ppcd_pkg::ppcd_pad_s e_pad_q;
  logic nmreq_q;
  logic mreq_q;

  // LCD wins first, then the alternative function, then GPIO
  assign tick_own = tick_en_i & ~lcd_seg_a_i[ppcd_pkg::A_BIT_TICK]; // RULE12
  assign nmreq_own = nmreq_en_i &
                     ~lcd_seg_a_i[ppcd_pkg::A_BIT_NMREQ]; // RULE13
  assign mreq_own = mreq_en_i & ~lcd_seg_a_i[ppcd_pkg::A_BIT_MREQ]; // RULE14

  always_comb begin
    a_dir_eff = reg_q[ppcd_pkg::IDX_A_DIR]; // RULE17
    a_data_eff = reg_q[ppcd_pkg::IDX_A_DATA];
    if (tick_own) begin
      a_dir_eff[ppcd_pkg::A_BIT_TICK] = 1'b1;
      a_data_eff[ppcd_pkg::A_BIT_TICK] = tick_clk_i; // RULE12
    end
    if (nmreq_own) begin
      a_dir_eff[ppcd_pkg::A_BIT_NMREQ] = 1'b0; // RULE13
    end
    if (mreq_own) begin
      a_dir_eff[ppcd_pkg::A_BIT_MREQ] = 1'b0; // RULE14
    end
  end

  assign a_cfg = '{dir: a_dir_eff, data: a_data_eff,
                   pull_en: reg_q[ppcd_pkg::IDX_A_PULL_EN],
                   pull_sel: ppcd_pkg::PS_FIXED_AB, // RULE5
                   reduce: reg_q[ppcd_pkg::IDX_A_REDUCE],
                   lcd: lcd_seg_a_i}; // RULE11
  assign b_cfg = '{dir: reg_q[ppcd_pkg::IDX_B_DIR],
                   data: reg_q[ppcd_pkg::IDX_B_DATA],
                   pull_en: reg_q[ppcd_pkg::IDX_B_PULL_EN],
                   pull_sel: ppcd_pkg::PS_FIXED_AB, // RULE5
                   reduce: reg_q[ppcd_pkg::IDX_B_REDUCE],
                   lcd: lcd_seg_b_i}; // RULE11
  assign e_cfg = '{dir: reg_q[ppcd_pkg::IDX_E_DIR],
                   data: reg_q[ppcd_pkg::IDX_E_DATA],
                   pull_en: reg_q[ppcd_pkg::IDX_E_PULL_EN],
                   pull_sel: e_sel, // RULE1
                   reduce: reg_q[ppcd_pkg::IDX_E_REDUCE],
                   lcd: ppcd_pkg::RST_REG};

  // Pads are registered: one cycle from config to pin, glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_pad_q <= '{oe_n: '1, default: '0};
      b_pad_q <= '{oe_n: '1, default: '0};
      e_pad_q <= '{oe_n: '1, default: '0};
      nmreq_q <= 1'b0;
      mreq_q <= 1'b0;
    end else begin
      a_pad_q <= pad_ctl(a_cfg); // RULE2 RULE4 RULE9 RULE18
      b_pad_q <= pad_ctl(b_cfg); // RULE2 RULE4 RULE9 RULE18
      e_pad_q <= pad_ctl(e_cfg); // RULE2 RULE4
      nmreq_q <= nmreq_own & a_in[ppcd_pkg::A_BIT_NMREQ];
      mreq_q <= mreq_own & a_in[ppcd_pkg::A_BIT_MREQ];
    end
  end

  assign a_pad_o = a_pad_q;
  assign b_pad_o = b_pad_q;
  assign e_pad_o = e_pad_q;
  assign nmreq_o = nmreq_q;
  assign mreq_o = mreq_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_bus_ack_one: assert property (req |=> ack_o ##1 !ack_o) // RULE7
    else $error("ack not a single pulse one cycle after request");
  a_read_src_dir: assert property (req && !we_i && hit && // RULE10
      idx == ppcd_pkg::IDX_B_DATA && reg_q[ppcd_pkg::IDX_B_DIR] == '1
      |=> dat_o[W-1:0] == $past(reg_q[ppcd_pkg::IDX_B_DATA]))
    else $error("port B read source wrong");
  a_write_a_data: assert property (wr && // RULE16
      idx == ppcd_pkg::IDX_A_DATA
      |=> reg_q[ppcd_pkg::IDX_A_DATA] == $past(dat_i[W-1:0]))
    else $error("port A data write lost");
  a_pull_ab_down: assert property (a_pad_o.pull_up == '0 && // RULE5
      b_pad_o.pull_up == '0)
    else $error("pull-up active on port A or B");
  a_out_no_pull: assert property ((~e_pad_o.oe_n & // RULE4
      (e_pad_o.pull_up | e_pad_o.pull_dn)) == '0)
    else $error("pull active on driven pin");
  a_pull_pol_e: assert property (!reg_q[ppcd_pkg::IDX_E_DIR][1] && // RULE2
      reg_q[ppcd_pkg::IDX_E_PULL_EN][1] |=> e_pad_o.pull_dn[1] ==
      $past(e_sel[1]) && e_pad_o.pull_up[1] == !$past(e_sel[1]))
    else $error("pull polarity wrong");
  a_lcd_owns_b: assert property (lcd_seg_b_i[0] |=> // RULE18
      b_pad_o.oe_n[0] && !b_pad_o.pull_dn[0])
    else $error("LCD pin not released");
  a_gpio_drive_b: assert property (!lcd_seg_b_i[2] && // RULE9
      reg_q[ppcd_pkg::IDX_B_DIR][2] |=> !b_pad_o.oe_n[2] &&
      b_pad_o.dout[2] == $past(reg_q[ppcd_pkg::IDX_B_DATA][2]))
    else $error("GPIO output not driving data");
  a_tick_out: assert property (tick_own |=> // RULE12
      !a_pad_o.oe_n[ppcd_pkg::A_BIT_TICK] &&
      a_pad_o.dout[ppcd_pkg::A_BIT_TICK] == $past(tick_clk_i))
    else $error("tick clock not on pin");
  a_nmreq_in: assert property (nmreq_own |=> // RULE13
      a_pad_o.oe_n[ppcd_pkg::A_BIT_NMREQ])
    else $error("nonmaskable pin not input");
  a_mreq_in: assert property (mreq_own |=> // RULE14
      a_pad_o.oe_n[ppcd_pkg::A_BIT_MREQ])
    else $error("maskable pin not input");
  a_edge_sets: assert property (e_event[0] |=> status_q[0]) // RULE3
    else $error("edge event lost");
  a_no_evt_off: assert property (!status_q[0] && // RULE6
      reg_q[ppcd_pkg::IDX_E_EVT_EN][0] == 1'b0 |=> !status_q[0])
    else $error("event flag set while disabled");

  c_read_a: cover property (req && !we_i && idx == ppcd_pkg::IDX_A_DATA);
  c_irq: cover property ($rose(irq_o));
  c_clear_race: cover property (e_event[0] && clr[0]);
  c_tick: cover property (tick_own ##1 tick_own);

endmodule

/* pkg/ppcd_pkg.sv */
package ppcd_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned WB_DW = 32;
  localparam int unsigned WB_AW = 8;
  // Word index sits above the byte offset within a 32-bit word
  localparam int unsigned IDX_LO = 2;
  localparam int unsigned IDX_W = 5;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_A_DATA = 5'h00;
  localparam logic [IDX_W-1:0] IDX_B_DATA = 5'h01;
  localparam logic [IDX_W-1:0] IDX_A_DIR = 5'h02;
  localparam logic [IDX_W-1:0] IDX_B_DIR = 5'h03;
  localparam logic [IDX_W-1:0] IDX_A_PULL_EN = 5'h04;
  localparam logic [IDX_W-1:0] IDX_B_PULL_EN = 5'h05;
  localparam logic [IDX_W-1:0] IDX_A_REDUCE = 5'h06;
  localparam logic [IDX_W-1:0] IDX_B_REDUCE = 5'h07;
  localparam logic [IDX_W-1:0] IDX_E_DATA = 5'h08;
  localparam logic [IDX_W-1:0] IDX_E_DIR = 5'h09;
  localparam logic [IDX_W-1:0] IDX_E_PULL_EN = 5'h0a;
  localparam logic [IDX_W-1:0] IDX_E_PULL_SEL = 5'h0b;
  localparam logic [IDX_W-1:0] IDX_E_REDUCE = 5'h0c;
  localparam logic [IDX_W-1:0] IDX_E_EVT_EN = 5'h0d;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 5'h0e;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 5'h0f;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 5'h10;
  localparam int unsigned NREG = 17;

  localparam logic [PORT_W-1:0] RST_REG = 8'h00;
  // Ports A and B have a hard-wired pull-down polarity
  localparam logic [PORT_W-1:0] PS_FIXED_AB = 8'hff;

  // Port A pins with alternative functions
  localparam int unsigned A_BIT_MREQ = 0;
  localparam int unsigned A_BIT_NMREQ = 1;
  localparam int unsigned A_BIT_TICK = 3;

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] data;
    logic [PORT_W-1:0] pull_en;
    logic [PORT_W-1:0] pull_sel;
    logic [PORT_W-1:0] reduce;
    logic [PORT_W-1:0] lcd;
  } ppcd_cfg_s;

  typedef struct packed {
    logic [PORT_W-1:0] oe_n;
    logic [PORT_W-1:0] dout;
    logic [PORT_W-1:0] pull_up;
    logic [PORT_W-1:0] pull_dn;
    logic [PORT_W-1:0] reduce;
  } ppcd_pad_s;

endpackage

/* verification/port_pin_config_and_data_tb_top.sv */
`timescale 1ns/1ns
module port_pin_config_and_data_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic [31:0] rdat;
  logic ack, nmreq, mreq, irq;
  logic [7:0] lcd_a = 8'h00;
  logic [7:0] lcd_b = 8'h00;
  logic tick_en = 1'b0;
  logic tick_clk = 1'b0;
  logic nm_en = 1'b0;
  logic m_en = 1'b0;
  logic [7:0] a_ev = 8'h00;
  logic [7:0] a_een = 8'hff;
  logic [7:0] b_ev = 8'hff;
  logic [7:0] e_ev = 8'h00;
  logic [7:0] a_pin, b_pin, e_pin;
  ppcd_pkg::ppcd_pad_s a_pad, b_pad, e_pad;
  int fail_count = 0;
  int total_checks = 0;

  always #5 clk_i = ~clk_i;

  ppcd_port dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .dat_o(rdat), .we_i(we), .sel_i(4'h1), .cyc_i(cyc), .stb_i(cyc),
    .ack_o(ack), .a_pin_i(a_pin), .b_pin_i(b_pin), .e_pin_i(e_pin),
    .lcd_seg_a_i(lcd_a), .lcd_seg_b_i(lcd_b), .tick_en_i(tick_en),
    .tick_clk_i(tick_clk), .nmreq_en_i(nm_en), .mreq_en_i(m_en),
    .a_pad_o(a_pad), .b_pad_o(b_pad), .e_pad_o(e_pad), .nmreq_o(nmreq),
    .mreq_o(mreq), .irq_o(irq));
  ppcd_pin_model pa (.clk_i(clk_i), .pad_i(a_pad), .ext_val_i(a_ev),
    .ext_en_i(a_een), .pin_o(a_pin));
  ppcd_pin_model pb (.clk_i(clk_i), .pad_i(b_pad), .ext_val_i(b_ev),
    .ext_en_i(8'hff), .pin_o(b_pin));
  ppcd_pin_model pe (.clk_i(clk_i), .pad_i(e_pad), .ext_val_i(e_ev),
    .ext_en_i(8'hff), .pin_o(e_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request stands until a rising edge samples ack; only the watchdog
  // ends a wait that never gets an answer
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat[7:0];
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  function automatic logic [7:0] ad(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] r;
    wb(ad(i), 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    wb(a, 1'b0, 8'h00, r);
    check(r, exp);
  endtask

  // Ends on a rising edge so the next stimulus lands on it; outputs read
  // here still hold what the previous edge launched
  task automatic settle;
    repeat (6) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check(a_pad.oe_n, 8'hff);
    wr(ppcd_pkg::IDX_A_DIR, 8'hff);
    wr(ppcd_pkg::IDX_B_DIR, 8'hff);
    rd(ad(ppcd_pkg::IDX_A_DATA), 8'h00);
    rd(ad(ppcd_pkg::IDX_B_DATA), 8'h00);
    a_ev <= 8'h3c;
    wr(ppcd_pkg::IDX_A_DATA, 8'ha5);
    wr(ppcd_pkg::IDX_A_REDUCE, 8'h0f);
    wr(ppcd_pkg::IDX_A_PULL_EN, 8'hff);
    rd(ad(ppcd_pkg::IDX_A_DATA), 8'ha5);
    settle();
    check(a_pad.dout, 8'ha5);
    check(a_pad.oe_n, 8'h00);
    check(a_pad.reduce, 8'h0f);
    check(a_pad.pull_dn, 8'h00);
    wr(ppcd_pkg::IDX_A_DIR, 8'h00);
    settle();
    rd(ad(ppcd_pkg::IDX_A_DATA), 8'h3c);
    check(a_pad.pull_dn, 8'hff);
    check(a_pad.pull_up, 8'h00);
    check(a_pad.reduce, 8'h00);
    a_een <= 8'h00;
    settle();
    rd(ad(ppcd_pkg::IDX_A_DATA), 8'h00);
    // LCD segments on the low nibble of port B
    lcd_b <= 8'h0f;
    wr(ppcd_pkg::IDX_B_PULL_EN, 8'hff);
    wr(ppcd_pkg::IDX_B_DATA, 8'hc3);
    wr(ppcd_pkg::IDX_B_REDUCE, 8'hff);
    settle();
    check(b_pad.oe_n, 8'h0f);
    check(b_pad.dout, 8'hc0);
    check(b_pad.reduce, 8'hf0);
    wr(ppcd_pkg::IDX_B_DIR, 8'h00);
    settle();
    check(b_pad.oe_n, 8'hff);
    check(b_pad.pull_dn, 8'hf0);
    check(b_pad.reduce, 8'h00);
    rd(ad(ppcd_pkg::IDX_B_DATA), 8'hf0);
    lcd_b <= 8'h00;
    tick_en <= 1'b1;
    tick_clk <= 1'b1;
    settle();
    check(a_pad.oe_n, 8'hf7);
    check(a_pad.dout[3], 1'b1);
    lcd_a <= 8'h08;
    settle();
    check(a_pad.oe_n, 8'hff);
    wr(ppcd_pkg::IDX_A_DIR, 8'hff);
    tick_en <= 1'b0;
    lcd_a <= 8'h00;
    nm_en <= 1'b1;
    m_en <= 1'b1;
    a_een <= 8'h03;
    a_ev <= 8'h03;
    settle();
    check(a_pad.oe_n, 8'h03);
    check({nmreq, mreq}, 8'h03);
    lcd_a <= 8'h01;
    settle();
    check(mreq, 1'b0);
    // Event port: bit 0 falling, bit 1 rising, bit 2 disabled
    e_ev <= 8'h03;
    rd(ad(ppcd_pkg::IDX_IRQ_STATUS), 8'h00);
    wr(ppcd_pkg::IDX_E_PULL_SEL, 8'h02);
    wr(ppcd_pkg::IDX_E_EVT_EN, 8'h03);
    wr(ppcd_pkg::IDX_IRQ_ENABLE, 8'h03);
    wr(ppcd_pkg::IDX_E_PULL_EN, 8'hff);
    settle();
    check(e_pad.pull_up, 8'hfd);
    e_ev <= 8'h04;
    settle();
    rd(ad(ppcd_pkg::IDX_IRQ_STATUS), 8'h01);
    check(irq, 1'b1);
    wr(ppcd_pkg::IDX_IRQ_CLEAR, 8'h01);
    e_ev <= 8'h03;
    settle();
    rd(ad(ppcd_pkg::IDX_IRQ_STATUS), 8'h02);
    wr(ppcd_pkg::IDX_IRQ_ENABLE, 8'h00);
    wr(ppcd_pkg::IDX_IRQ_STATUS, 8'hff);
    settle();
    check(irq, 1'b0);
    rd(ad(ppcd_pkg::IDX_IRQ_STATUS), 8'h02);
    rd(ad(ppcd_pkg::IDX_IRQ_CLEAR), 8'h00);
    wr(ppcd_pkg::IDX_IRQ_CLEAR, 8'hff);
    wr(ppcd_pkg::IDX_E_DIR, 8'h02);
    settle();
    check(e_pad.oe_n, 8'hfd);
    wr(ppcd_pkg::IDX_E_DATA, 8'h02);
    settle();
    check(e_pad.dout, 8'h02);
    rd(ad(ppcd_pkg::IDX_IRQ_STATUS), 8'h02);
    rd(8'h7c, 8'h00);
    rd(8'h80, 8'h00);
    tally_and_finish();
  end
endmodule

/* verification/ppcd_pin_model.sv */
`timescale 1ns/1ns
module ppcd_pin_model (
  input wire logic clk_i,
  input wire ppcd_pkg::ppcd_pad_s pad_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_o
);
  // Floating pins toggle so a stale level never reads back as valid
  logic [7:0] float_q = 8'h55;
  always @(posedge clk_i) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_i.oe_n[i]) pin_o[i] = pad_i.dout[i];
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pad_i.pull_up[i]) pin_o[i] = 1'b1;
      else if (pad_i.pull_dn[i]) pin_o[i] = 1'b0;
      else pin_o[i] = float_q[i];
    end
  end
endmodule
